/* File: core/usur_register_port.sv */
// Serial channel register port of the USB-to-serial bridge.
// Assumes the protocol engine delivers decoded setup packets on sys_clk and
// the serial core takes characters with a valid/ready handshake and delivers received ones on rx_valid alone.
//
// Notes on behaviour
// RQ1: Eight byte registers, mapping follows divisor select.
// RQ2: Offset zero write loads transmit holding.
// RQ3: Offset zero read returns receive holding.
// RQ4: Divisor select exposes divisor low/high bytes.
// RQ5: Enable bit 0 gates receive ready.
// RQ6: Enable bit 1 gates transmit empty.
// RQ7: Enable bit 2 gates receive line status.
// RQ8: Enable bit 3 gates modem change.
// RQ9: Enable bit 4 stops channel clock.
// RQ10: Control, bulk in/out, interrupt endpoints exposed.
// RQ11: Standard requests in hardware; bus powered only.
// RQ12: Vendor requests become register reads and writes.
// RQ13: Line recovered by four-times oversampling.
// RQ14: Logic clock comes from crystal multiplier.
// RQ15: Protocol engine does framing, checks, handshakes.
// RQ16: Line status errors raise interrupt, cleared on read.
// RQ17: Status reads 000001 idle, else top source.
// RQ18: Enable bits 7..5 read zero.
// RQ19: Scratch byte stores and returns any value.
`timescale 1ns/10ps
`default_nettype none
module usur_register_port
  import usur_pkg::*;
(
  // Clock and reset
  input  wire logic     sys_clk,
  input  wire logic     reset_n,
  input  wire logic     clk_en,
  // Setup requests from the protocol engine
  input  wire logic     setup_valid,
  input  wire usur_setup_t setup,
  output logic          resp_valid,
  output logic          resp_stall,
  output logic [7:0]    resp_data,
  // Interrupt endpoint
  output logic          intr_valid,
  output usur_intr_msg_t intr_msg,
  output logic          irq_pending,
  // Serial core, transmit side
  output logic          tx_valid,
  output logic [7:0]    tx_data,
  input  wire logic     tx_ready,
  input  wire logic     tx_idle,
  // Serial core, receive side
  input  wire logic     rx_valid,
  input  wire usur_rx_char_t rx_char,
  // Serial core configuration
  output logic [15:0]   divisor,
  output logic [7:0]    line_format_control,
  output logic [7:0]    queue_control,
  output logic          chan_clk_en,
  // Modem pins
  input  wire logic     cd_n,
  input  wire logic     ri_n,
  input  wire logic     dsr_n,
  input  wire logic     cts_n,
  output logic          rts_n,
  output logic          dtr_n,
  // Upstream line sampling
  input  wire logic     usb_line_in,
  input  wire logic     sample_tick,
  output logic          rec_bit,
  output logic          rec_valid
);

  usur_state_t st;       // Registered state
  usur_state_t next_st;  // Next state

  logic       is_vendor;  // Vendor class request
  logic       do_wr;      // Register write request
  logic       do_rd;      // Register read request
  logic [2:0] off;        // Decoded offset
  logic [7:0] wbyte;      // Write data
  logic       divisor_window_select;        // Divisor window selected
  logic [5:0] isr_now;    // Current status code
  logic [7:0] lsr_now;    // Current line state
  logic [7:0] msr_now;    // Current modem line state

  // Highest pending source, priority fixed by level
  function automatic logic [5:0] usur_isr_code(input usur_state_t s);
    logic [5:0] code;
    code = ISR_NONE;                                                       // RQ17
    if (s.interrupt_enable[IER_MODEM] && (|s.modem_delta))
      code = ISR_MODEM;                                                    // RQ8
    if (s.interrupt_enable[IER_TX_EMPTY] && s.transmit_empty_irq_irq)
      code = ISR_TX_EMPTY;                                                 // RQ6
    if (s.interrupt_enable[IER_RX_READY] && s.rx_ready)
      code = ISR_RX_DATA;                                                  // RQ5
    if (s.interrupt_enable[IER_RX_STATUS] && (|s.rx_err))
      code = ISR_RX_STATUS;                                                // RQ7 RQ16
    return code;
  endfunction : usur_isr_code

  // Read value at an offset, window chosen by divisor select
  function automatic logic [7:0] usur_read_mux(input usur_state_t s, input logic [2:0] o,
                                               input logic [7:0] line_state, input logic [7:0] modem_line_state,
                                               input logic [5:0] interrupt_status);
    logic [7:0] r;
    r = RST_BYTE;
    case (o)
      OFF_DATA: r = s.line_format_control[LCR_DIV_SEL] ? s.div_low : s.receive_holding;
      OFF_IER:  r = s.line_format_control[LCR_DIV_SEL] ? s.div_high : s.interrupt_enable;
      OFF_QCTL: r = {{2{s.queue_control[QCTL_ENABLE]}}, interrupt_status};
      OFF_LCR:  r = s.line_format_control;
      OFF_MCR:  r = s.modem_line_control;
      OFF_LSR:  r = line_state;
      OFF_MSR:  r = modem_line_state;
      OFF_SCR:  r = s.scratch_byte;                                        // RQ19
      default:  r = RST_BYTE;
    endcase
    return r;
  endfunction : usur_read_mux

  // Request decode; standard requests are taken by the engine, not here
  always_comb
  begin
    is_vendor = setup_valid && (setup.req_type[6:5] == REQ_TYPE_VENDOR);   // RQ11
    do_wr     = is_vendor && !setup.req_type[7] && (setup.request == VND_WRITE_REG); // RQ12
    do_rd     = is_vendor && setup.req_type[7] && (setup.request == VND_READ_REG);   // RQ12
    off       = setup.index[2:0];
    wbyte     = setup.value[7:0];
    divisor_window_select       = st.line_format_control[LCR_DIV_SEL];                       // RQ1
    isr_now   = usur_isr_code(st);
    lsr_now   = {|st.rx_err, st.thr_empty && tx_idle, st.thr_empty, st.rx_err, st.rx_ready};
    msr_now   = {st.modem_s2, st.modem_delta};
  end

  // Next state: read side-effect clears are applied first so that sets in the same cycle win
  always_comb
  begin
    next_st            = st;
    next_st.resp_valid = 1'b0;
    next_st.resp_stall = 1'b0;
    next_st.intr_valid = 1'b0;
    // Modem pins: two stages before any logic looks at them
    next_st.modem_s1   = ~{cd_n, ri_n, dsr_n, cts_n};
    next_st.modem_s2   = st.modem_s1;
    next_st.modem_prev = st.modem_s2;

    // Reads and their side effects
    if (do_rd)
    begin
      next_st.resp_valid = 1'b1;
      next_st.resp_data  = usur_read_mux(st, off, lsr_now, msr_now, isr_now); // RQ12
      if ((off == OFF_DATA) && !divisor_window_select)
        next_st.rx_ready = 1'b0;                                           // RQ3
      if (off == OFF_LSR)
        next_st.rx_err = '0;                                               // RQ16
      if (off == OFF_MSR)
        next_st.modem_delta = '0;
      if ((off == OFF_QCTL) && (isr_now == ISR_TX_EMPTY))
        next_st.transmit_empty_irq_irq = 1'b0;
    end
    else if (is_vendor && !do_wr)
      next_st.resp_stall = 1'b1;  // Unknown vendor code

    // Character taken by the serial core
    if (st.tx_valid && tx_ready)
    begin
      next_st.tx_valid  = 1'b0;
      next_st.thr_empty = 1'b1;
      next_st.transmit_empty_irq_irq  = 1'b1;
    end

    // Writes
    if (do_wr)
    begin
      next_st.resp_valid = 1'b1;  // Zero-length status stage
      case (off)
        OFF_DATA:
        begin
          if (divisor_window_select)
            next_st.div_low = wbyte;                                       // RQ4
          else
          begin
            next_st.tx_data   = wbyte;                                     // RQ2
            next_st.tx_valid  = 1'b1;
            next_st.thr_empty = 1'b0;
            next_st.transmit_empty_irq_irq  = 1'b0;
          end
        end
        OFF_IER:
        begin
          if (divisor_window_select)
            next_st.div_high = wbyte;                                      // RQ4
          else
            next_st.interrupt_enable = {3'h0, wbyte[IER_LIVE_BITS-1:0]};   // RQ18
        end
        OFF_QCTL: next_st.queue_control       = wbyte;
        OFF_LCR:  next_st.line_format_control = wbyte;
        OFF_MCR:  next_st.modem_line_control  = wbyte;
        OFF_SCR:  next_st.scratch_byte        = wbyte;                     // RQ19
        default:  next_st.scratch_byte        = st.scratch_byte;  // Read-only offsets
      endcase
    end

    // Received character; overrun if the last one was never read
    if (rx_valid)
    begin
      // Overrun looks at the ready flag before this character sets it
      next_st.rx_err          = next_st.rx_err |
                                {rx_char.brk, rx_char.framing, rx_char.parity, next_st.rx_ready}; // RQ16
      next_st.receive_holding = rx_char.data;
      next_st.rx_ready        = 1'b1;
    end

    // Modem change flags: any change, ring only on its trailing edge
    next_st.modem_delta = next_st.modem_delta |
                          {st.modem_s2[3] ^ st.modem_prev[3],
                           st.modem_prev[2] & ~st.modem_s2[2],
                           st.modem_s2[1:0] ^ st.modem_prev[1:0]};

    // Notify the interrupt endpoint when the status code changes to a pending one
    next_st.isr_last = isr_now;
    if ((isr_now != st.isr_last) && !isr_now[0])
      next_st.intr_valid = 1'b1;                                           // RQ10
  end

  // State register; the clock enable freezes everything
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      st                     <= '0;
      st.line_format_control <= RST_LCR;
      st.thr_empty           <= 1'b1;
      st.isr_last            <= ISR_NONE;
    end
    else if (clk_en)
      st <= next_st;
  end

  // Line recovery; the 4x tick derives from the multiplied logic clock
  usur_bit_recover u_rec (                                                 // RQ13 RQ14 RQ15
    .sys_clk     (sys_clk),
    .reset_n     (reset_n),
    .clk_en      (clk_en),
    .line_in     (usb_line_in),
    .sample_tick (sample_tick),
    .rec_bit     (rec_bit),
    .rec_valid   (rec_valid)
  );

  // Outputs
  assign resp_valid          = st.resp_valid;
  assign resp_stall          = st.resp_stall;
  assign resp_data           = st.resp_data;
  assign intr_valid          = st.intr_valid;
  assign intr_msg            = '{ep: EP_INTR, status: {2'h0, st.isr_last}};
  assign irq_pending         = !st.isr_last[0];                            // RQ17
  assign tx_valid            = st.tx_valid;
  assign tx_data             = st.tx_data;
  assign divisor             = {st.div_high, st.div_low};                  // RQ4
  assign line_format_control = st.line_format_control;
  assign queue_control       = st.queue_control;
  assign chan_clk_en         = !st.interrupt_enable[IER_SLEEP];            // RQ9
  // Modem outputs go inactive in loop-back
  assign rts_n = !(st.modem_line_control[MCR_RTS] && !st.modem_line_control[MCR_LOOP]);
  assign dtr_n = !(st.modem_line_control[MCR_DTR] && !st.modem_line_control[MCR_LOOP]);

endmodule : usur_register_port
`default_nettype wire

/* File: core/usur_pkg.sv */
// Package for the serial channel register port of the USB bridge.
// Assumes one 40 MHz system clock and a protocol engine on that same clock.
package usur_pkg;

  // Register offsets within the channel
  localparam logic [2:0] OFF_DATA  = 3'h0;  // Holding registers / divisor low
  localparam logic [2:0] OFF_IER   = 3'h1;  // Interrupt enable / divisor high
  localparam logic [2:0] OFF_QCTL  = 3'h2;  // Queue control (W) / interrupt status (R)
  localparam logic [2:0] OFF_LCR   = 3'h3;  // Line format control
  localparam logic [2:0] OFF_MCR   = 3'h4;  // Modem line control
  localparam logic [2:0] OFF_LSR   = 3'h5;  // Line state
  localparam logic [2:0] OFF_MSR   = 3'h6;  // Modem line state
  localparam logic [2:0] OFF_SCR   = 3'h7;  // Scratch byte

  // Field positions
  localparam int IER_RX_READY  = 0;  // Receive ready enable
  localparam int IER_TX_EMPTY  = 1;  // Transmit empty enable
  localparam int IER_RX_STATUS = 2;  // Receive line status enable
  localparam int IER_MODEM     = 3;  // Modem change enable
  localparam int IER_SLEEP     = 4;  // Channel clock stop
  localparam int IER_LIVE_BITS = 5;  // Bits that store; the rest read zero
  localparam int LCR_DIV_SEL   = 7;  // Divisor window select
  localparam int MCR_DTR       = 0;
  localparam int MCR_RTS       = 1;
  localparam int MCR_LOOP      = 4;
  localparam int QCTL_ENABLE   = 0;  // Queue mode enable

  // Reset values
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [7:0] RST_LCR  = 8'h00;

  // Interrupt status codes, bits 5..0
  localparam logic [5:0] ISR_NONE      = 6'h01;
  localparam logic [5:0] ISR_RX_STATUS = 6'h06;
  localparam logic [5:0] ISR_RX_DATA   = 6'h04;
  localparam logic [5:0] ISR_TX_EMPTY  = 6'h02;
  localparam logic [5:0] ISR_MODEM     = 6'h00;

  // Setup packet decode
  localparam logic [1:0] REQ_TYPE_VENDOR = 2'h2;   // Type field of request type
  localparam logic [7:0] VND_WRITE_REG   = 8'h0e;  // Vendor register write code
  localparam logic [7:0] VND_READ_REG    = 8'h0d;  // Vendor register read code

  // Endpoint numbers of the function
  localparam logic [3:0] EP_CONTROL  = 4'h0;
  localparam logic [3:0] EP_BULK_IN  = 4'h1;
  localparam logic [3:0] EP_BULK_OUT = 4'h2;
  localparam logic [3:0] EP_INTR     = 4'h3;

  // Bit recovery
  localparam logic [1:0] REC_SAMPLE_PHASE = 2'h2;  // Mid-bit sample point after an edge

  // Setup packet from the protocol engine
  typedef struct packed {
    logic [7:0]  req_type;  // Bit 7 direction, 6:5 type
    logic [7:0]  request;
    logic [15:0] value;     // Low byte is write data
    logic [15:0] index;     // Low three bits are the offset
  } usur_setup_t;

  // Message for the interrupt endpoint
  typedef struct packed {
    logic [3:0] ep;
    logic [7:0] status;
  } usur_intr_msg_t;

  // Received character from the serial core
  typedef struct packed {
    logic [7:0] data;
    logic       brk;      // Break seen
    logic       framing;  // Framing error
    logic       parity;   // Parity error
  } usur_rx_char_t;

  // Bit recovery state
  typedef struct packed {
    logic       s1;
    logic       s2;
    logic       prev;
    logic [1:0] phase;
    logic       bit_out;
    logic       valid;
  } usur_rec_state_t;

  // Register port state
  typedef struct packed {
    logic [7:0] div_low;
    logic [7:0] div_high;
    logic [7:0] interrupt_enable;
    logic [7:0] queue_control;
    logic [7:0] line_format_control;
    logic [7:0] modem_line_control;
    logic [7:0] scratch_byte;
    logic [7:0] receive_holding;
    logic       rx_ready;
    logic [3:0] rx_err;       // Break, framing, parity, overrun
    logic       thr_empty;
    logic       transmit_empty_irq_irq;
    logic [3:0] modem_delta;  // Dcd, trailing ring, dsr, cts
    logic [3:0] modem_s1;
    logic [3:0] modem_s2;
    logic [3:0] modem_prev;
    logic [7:0] tx_data;
    logic       tx_valid;
    logic       resp_valid;
    logic       resp_stall;
    logic [7:0] resp_data;
    logic [5:0] isr_last;
    logic       intr_valid;
  } usur_state_t;

endpackage : usur_pkg

/* File: core/usur_bit_recover.sv */
// Oversampling bit clock recovery for the upstream line.
// Assumes sample_tick pulses at four times the bit rate on sys_clk.
`timescale 1ns/10ps
`default_nettype none
module usur_bit_recover
  import usur_pkg::*;
(
  // Clock and reset
  input  wire logic sys_clk,
  input  wire logic reset_n,
  input  wire logic clk_en,
  // Line side
  input  wire logic line_in,
  input  wire logic sample_tick,
  // Recovered stream
  output logic      rec_bit,
  output logic      rec_valid
);

  usur_rec_state_t st;       // Registered state
  usur_rec_state_t next_st;  // Next state

  // Phase restarts on every edge, so jitter and drift are tracked
  always_comb
  begin
    next_st       = st;
    next_st.s1    = line_in;
    next_st.s2    = st.s1;
    next_st.valid = 1'b0;
    if (sample_tick)
    begin
      next_st.prev = st.s2;
      if (st.s2 != st.prev)
        next_st.phase = '0;  // RQ13
      else
        next_st.phase = st.phase + 2'h1;
      // Sample at mid-bit
      if (next_st.phase == REC_SAMPLE_PHASE)
      begin
        next_st.bit_out = st.s2;  // RQ13
        next_st.valid   = 1'b1;
      end
    end
  end

  // State register
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      st <= '0;
    else if (clk_en)
      st <= next_st;
  end

  assign rec_bit   = st.bit_out;
  assign rec_valid = st.valid;

endmodule : usur_bit_recover
`default_nettype wire

/* File: testbench/usur_register_port_chk.sv */
// Checker for the register port, watching only top-level ports.
// Assumes it is bound onto usur_register_port in the testbench.
`timescale 1ns/10ps
`default_nettype none
module usur_register_port_chk
  import usur_pkg::*;
(
  // Clock and reset
  input wire logic        sys_clk,
  input wire logic        reset_n,
  input wire logic        clk_en,
  // Register requests and answers
  input wire logic        setup_valid,
  input wire usur_setup_t setup,
  input wire logic        resp_valid,
  input wire logic [7:0]  resp_data,
  input wire logic        irq_pending,
  input wire logic        intr_valid,
  input wire usur_intr_msg_t intr_msg,
  // Transmit side and configuration
  input wire logic        tx_valid,
  input wire logic [7:0]  tx_data,
  input wire logic        tx_ready,
  input wire logic [15:0] divisor,
  input wire logic [7:0]  line_format_control,
  input wire logic        chan_clk_en
);
  logic       wr;   // Vendor write taken
  logic       rd;   // Vendor read taken
  logic [2:0] off;  // Offset of the request
  logic       divisor_window_select;  // Divisor window open
  assign wr  = setup_valid && clk_en && setup.req_type[7:5] == 3'h2
               && setup.request == VND_WRITE_REG;
  assign rd  = setup_valid && clk_en && setup.req_type[7:5] == 3'h6
               && setup.request == VND_READ_REG;
  assign off = setup.index[2:0];
  assign divisor_window_select = line_format_control[LCR_DIV_SEL];

  // All checks share the one clock and reset
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!reset_n);

  AST_ANSWER: assert property ((wr || rd) |=> resp_valid)
    else $error("register request not answered");
  AST_TX_LOAD: assert property (wr && off == OFF_DATA && !divisor_window_select
    |=> tx_valid && tx_data == $past(setup.value[7:0])) else $error("transmit byte not loaded");
  AST_TX_HOLD: assert property (clk_en && tx_valid && !tx_ready && !wr
    |=> tx_valid && $stable(tx_data)) else $error("transmit byte dropped");
  AST_DIV_LOW: assert property (wr && off == OFF_DATA && divisor_window_select
    |=> divisor[7:0] == $past(setup.value[7:0]) && $stable(tx_data))
    else $error("divisor low byte wrong");
  AST_DIV_HIGH: assert property (wr && off == OFF_IER && divisor_window_select
    |=> divisor[15:8] == $past(setup.value[7:0])) else $error("divisor high byte wrong");
  AST_DIV_READ: assert property (rd && off == OFF_DATA && divisor_window_select
    |=> resp_data == divisor[7:0]) else $error("divisor low read wrong");
  AST_SLEEP: assert property (wr && off == OFF_IER && !divisor_window_select
    |=> chan_clk_en == !$past(setup.value[IER_SLEEP])) else $error("sleep gate wrong");
  AST_IER_RSVD: assert property (rd && off == OFF_IER && !divisor_window_select
    |=> resp_data[7:5] == 3'h0) else $error("reserved enable bits not zero");
  AST_IDLE_CODE: assert property (rd && off == OFF_QCTL
    |=> (resp_data[5:0] == ISR_NONE) == !irq_pending) else $error("idle status code wrong");
  AST_INTR_MSG: assert property (intr_valid |-> irq_pending && intr_msg.ep == EP_INTR
    && intr_msg.status[5:0] != ISR_NONE) else $error("interrupt message wrong");
endmodule : usur_register_port_chk
`default_nettype wire

/* File: testbench/usur_host_model.sv */
// Host side model: issues vendor register requests as setup packets.
// Assumes the register port answers within a few cycles.
`timescale 1ns/10ps
`default_nettype none
module usur_host_model
  import usur_pkg::*;
(
  // Clock
  input  wire logic       sys_clk,
  // Requests
  output var logic        setup_valid,
  output usur_setup_t     setup,
  // Answers
  input  wire logic       resp_valid,
  input  wire logic [7:0] resp_data
);
  initial
  begin
    setup_valid = 1'b0;
    setup = '0;
  end

  // One vendor request, held one cycle, then a bounded wait for the answer
  task automatic xfer(input logic rnw, input logic [2:0] off, input logic [7:0] wd,
                      output logic [7:0] rdat, output logic ok);
    int n;
    ok = 1'b0;
    rdat = 8'h00;
    @(posedge sys_clk);
    setup_valid <= 1'b1;
    setup <= {rnw, REQ_TYPE_VENDOR, 5'h00, rnw ? VND_READ_REG : VND_WRITE_REG,
              8'h00, wd, 13'h0000, off};
    @(posedge sys_clk);
    setup_valid <= 1'b0;
    setup <= ~setup; // Released packet shows junk, not stale data
    for (n = 0; n < 4 && !ok; n++)
    begin
      #1;
      ok = resp_valid;
      rdat = resp_data;
      if (!ok)
        @(posedge sys_clk);
    end
  endtask : xfer
endmodule : usur_host_model
`default_nettype wire

/* File: testbench/tb.sv */
// Self-checking bench for the register port.
// Assumes the host model drives requests; serial core and pins driven here.
`timescale 1ns/10ps
`default_nettype none
module tb;
  import usur_pkg::*;
  logic          sys_clk, reset_n, clk_en, tx_ready, tx_idle, rx_valid, setup_valid;
  logic          cd_n, ri_n, dsr_n, cts_n, resp_valid, tx_valid, irq_pending;
  logic          chan_clk_en, rts_n, dtr_n, ok;
  logic [7:0]    resp_data, tx_data, got;
  logic [15:0]   divisor;
  logic [5:0]    cnt;       // Drives the line sampling inputs
  usur_setup_t   setup;
  usur_rx_char_t rx_char;
  int            err_count, n_compared;
  wire logic     usb_line_in = cnt[4];
  wire logic     sample_tick = (cnt[1:0] == 2'h0);

  usur_register_port usur_register_port_i (.sys_clk, .reset_n, .clk_en, .setup_valid,
    .setup, .resp_valid, .resp_stall(), .resp_data, .intr_valid(), .intr_msg(),
    .irq_pending, .tx_valid, .tx_data, .tx_ready, .tx_idle, .rx_valid, .rx_char,
    .divisor, .line_format_control(), .queue_control(), .chan_clk_en, .cd_n, .ri_n,
    .dsr_n, .cts_n, .rts_n, .dtr_n, .usb_line_in, .sample_tick, .rec_bit(), .rec_valid());
  usur_host_model usur_host_model_i (.sys_clk, .setup_valid, .setup, .resp_valid,
    .resp_data);

  initial
  begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk)
    cnt <= cnt + 6'h01;

  task automatic end_sim();
    $display("compared %0d mismatched %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : end_sim
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      err_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  // Request through the host model; a lost answer ends the run
  task automatic xfer(input logic rnw, input logic [2:0] off, input logic [7:0] d);
    usur_host_model_i.xfer(rnw, off, d, got, ok);
    if (!ok)
    begin
      err_count++;
      end_sim();
    end
  endtask : xfer
  task automatic wr(input logic [2:0] off, input logic [7:0] d);
    xfer(1'b0, off, d);
  endtask : wr
  task automatic rd(input logic [2:0] off, input logic [7:0] exp);
    xfer(1'b1, off, 8'h00);
    chk(16'(got), 16'(exp));
  endtask : rd
  // Serial core takes the pending byte
  task automatic send();
    @(posedge sys_clk);
    tx_ready <= 1'b1;
    @(posedge sys_clk);
    tx_ready <= 1'b0;
    #1;
    chk(16'(tx_valid), 16'h0);
  endtask : send
  task automatic rxin(input logic [7:0] d, input logic [2:0] e);
    @(posedge sys_clk);
    rx_valid <= 1'b1;
    rx_char <= {d, e};
    @(posedge sys_clk);
    rx_valid <= 1'b0;
    rx_char <= ~{d, e};
  endtask : rxin

  task automatic t_regs();
    rd(OFF_QCTL, 8'h01);
    wr(OFF_SCR, 8'ha5);
    rd(OFF_SCR, 8'ha5);
    chk(16'({rts_n, dtr_n}), 16'h3);
    wr(OFF_MCR, 8'h03);
    chk(16'({rts_n, dtr_n}), 16'h0);
    wr(OFF_MCR, 8'h13);
    chk(16'({rts_n, dtr_n}), 16'h3);
    // A character offered while frozen must leave no trace
    @(posedge sys_clk);
    clk_en <= 1'b0;
    rxin(8'hee, 3'h7);
    @(posedge sys_clk);
    clk_en <= 1'b1;
    rd(OFF_LSR, 8'h60);
    wr(OFF_IER, 8'hff);
    rd(OFF_IER, 8'h1f);
    chk(16'(chan_clk_en), 16'h0);
    wr(OFF_IER, 8'h00);
    chk(16'(chan_clk_en), 16'h1);
    $display("t_regs done");
  endtask : t_regs
  task automatic t_tx();
    wr(OFF_IER, 8'h02);
    wr(OFF_DATA, 8'hab);
    chk(16'(tx_valid), 16'h1);
    wr(OFF_DATA, 8'h3c);
    chk(16'(tx_data), 16'h003c);
    rd(OFF_QCTL, 8'h01);
    send();
    rd(OFF_LSR, 8'h60);
    rd(OFF_QCTL, 8'h02);
    rd(OFF_QCTL, 8'h01);
    wr(OFF_IER, 8'h00);
    wr(OFF_DATA, 8'h77);
    send();
    rd(OFF_QCTL, 8'h01);
    $display("t_tx done");
  endtask : t_tx
  task automatic t_rx();
    rxin(8'h5a, 3'h0);
    rd(OFF_QCTL, 8'h01);
    wr(OFF_IER, 8'h01);
    rd(OFF_QCTL, 8'h04);
    rd(OFF_DATA, 8'h5a);
    rd(OFF_QCTL, 8'h01);
    wr(OFF_IER, 8'h00);
    rxin(8'h11, 3'h2);
    rd(OFF_QCTL, 8'h01);
    wr(OFF_IER, 8'h04);
    rd(OFF_QCTL, 8'h06);
    rd(OFF_LSR, 8'he9);
    rd(OFF_LSR, 8'h61);
    rd(OFF_QCTL, 8'h01);
    rd(OFF_DATA, 8'h11);
    rxin(8'h22, 3'h0);
    rxin(8'h33, 3'h0);
    rd(OFF_LSR, 8'he3);
    rd(OFF_DATA, 8'h33);
    $display("t_rx done");
  endtask : t_rx
  task automatic t_div();
    wr(OFF_LCR, 8'h80);
    wr(OFF_DATA, 8'h34);
    wr(OFF_IER, 8'h12);
    chk(divisor, 16'h1234);
    chk(16'(tx_valid), 16'h0);
    rd(OFF_DATA, 8'h34);
    wr(OFF_LCR, 8'h03);
    rd(OFF_IER, 8'h04);
    rd(OFF_LCR, 8'h03);
    $display("t_div done");
  endtask : t_div
  task automatic t_modem();
    wr(OFF_IER, 8'h08);
    rd(OFF_QCTL, 8'h01);
    @(posedge sys_clk);
    cts_n <= 1'b0;
    repeat (4) @(posedge sys_clk);
    rd(OFF_QCTL, 8'h00);
    chk(16'(irq_pending), 16'h1);
    rd(OFF_MSR, 8'h11);
    rd(OFF_QCTL, 8'h01);
    chk(16'(irq_pending), 16'h0);
    $display("t_modem done");
  endtask : t_modem

  initial
  begin
    {clk_en, tx_idle, cd_n, ri_n, dsr_n, cts_n} = 6'h3f;
    {reset_n, tx_ready, rx_valid} = 3'h0;
    rx_char = '0;
    cnt = '0;
    err_count = 0;
    n_compared = 0;
    repeat (2) @(posedge sys_clk);
    reset_n <= 1'b1;
    t_regs();
    t_tx();
    t_rx();
    t_div();
    t_modem();
    end_sim();
  end
endmodule : tb

bind usur_register_port usur_register_port_chk usur_register_port_chk_i (.sys_clk,
  .reset_n, .clk_en, .setup_valid, .setup, .resp_valid, .resp_data, .irq_pending,
  .intr_valid, .intr_msg,
  .tx_valid, .tx_data, .tx_ready, .divisor, .line_format_control, .chan_clk_en);
`default_nettype wire
